// ===== rtl/sls_link.sv
/*
 * One receive link: multiframe sync machine and local multiframe clock.
 * Assumes sysref_edge is a one-cycle pulse on mclk and that all control
 * inputs are registered in the instantiating module.
 */
`timescale 1ns/1ps
`include "sls_params.svh"

module sls_link (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       link_enable,
    input  wire logic       sync_enable,
    input  wire logic       sync_arm,
    input  wire logic [1:0] sync_mode,
    input  wire logic       sysref_edge,
    output logic            locked,
    output logic            lmfc_pulse
);

    typedef struct packed {
        sls_pkg::sls_link_state_t st;
        logic [7:0]               cnt;
        logic                     pulse;
        logic                     locked;
    } sls_link_state_reg_t;

    sls_link_state_reg_t q;
    sls_link_state_reg_t d;

    // ------------------------------------------------------------------
    // sync machine
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.cnt = (q.cnt == `SLS_LMFC_LAST) ? `SLS_LMFC_ZERO : q.cnt + `SLS_LMFC_STEP;
        case (q.st)
            sls_pkg::SLS_LINK_IDLE:
            begin
                if (sync_mode != `SLS_SYNC_MODE_OFF)
                    d.st = sls_pkg::SLS_LINK_WAIT;
            end
            sls_pkg::SLS_LINK_WAIT:
            begin
                if (sync_arm && sysref_edge)
                begin
                    d.st  = sls_pkg::SLS_LINK_LOCKED;
                    d.cnt = `SLS_LMFC_ZERO;
                end
            end
            sls_pkg::SLS_LINK_LOCKED:
            begin
                // one-shot ignores later edges, continuous realigns
                if (sync_mode == `SLS_SYNC_MODE_CONT && sysref_edge)
                    d.cnt = `SLS_LMFC_ZERO;
            end
            default:
                d.st = sls_pkg::SLS_LINK_IDLE;
        endcase
        if (!link_enable || !sync_enable)
            d.st = sls_pkg::SLS_LINK_IDLE;
        d.locked = (d.st == sls_pkg::SLS_LINK_LOCKED);
        d.pulse  = d.locked && (d.cnt == `SLS_LMFC_ZERO);
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            q <= '{sls_pkg::SLS_LINK_IDLE, `SLS_LMFC_ZERO, 1'b0, 1'b0};
        else
            q <= d;
    end

    assign locked     = q.locked;
    assign lmfc_pulse = q.pulse;

endmodule : sls_link

// ===== rtl/sls_params.svh
/*
 * Constants of the link layer setup block: register addresses, field
 * positions, reset values and multiframe timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SLS_PARAMS_SVH
`define SLS_PARAMS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define SLS_ADDR_SYNC_CONTROL   12'h03a
`define SLS_ADDR_SYNC_STATUS    12'h03b
`define SLS_ADDR_PLL_CONTROL    12'h280
`define SLS_ADDR_PLL_STATUS     12'h281
`define SLS_ADDR_LINK_CONTROL   12'h300
`define SLS_ADDR_SUBCLASS       12'h301
`define SLS_ADDR_MF_DELAY_A     12'h304
`define SLS_ADDR_MF_DELAY_B     12'h305
`define SLS_ADDR_MF_WINDOW_A    12'h306
`define SLS_ADDR_MF_WINDOW_B    12'h307
`define SLS_ADDR_XBAR_0         12'h308
`define SLS_ADDR_XBAR_1         12'h309
`define SLS_ADDR_XBAR_2         12'h30a
`define SLS_ADDR_XBAR_3         12'h30b
`define SLS_ADDR_POLARITY       12'h334

// ----------------------------------------------------------------------
// field positions and sync mode codes
// ----------------------------------------------------------------------
`define SLS_SYNC_EN_BIT         7
`define SLS_SYNC_ARM_BIT        6
`define SLS_SYNC_MODE_LSB       0
`define SLS_SYNC_LOCK_BIT       3
`define SLS_CHECKSUM_BIT        6
`define SLS_TWO_LINK_BIT        3
`define SLS_STATUS_SEL_BIT      2
`define SLS_PLL_BIT             0
`define SLS_SYNC_MODE_ONESHOT   2'h1
`define SLS_SYNC_MODE_CONT      2'h2
`define SLS_SYNC_MODE_OFF       2'h0

// ----------------------------------------------------------------------
// reset values (crossbar resets to identity map)
// ----------------------------------------------------------------------
`define SLS_RST_BYTE            8'h00
`define SLS_RST_XBAR_0          8'h08
`define SLS_RST_XBAR_1          8'h1a
`define SLS_RST_XBAR_2          8'h2c
`define SLS_RST_XBAR_3          8'h3e

// ----------------------------------------------------------------------
// multiframe timing
// ----------------------------------------------------------------------
`define SLS_LMFC_LAST           8'h1f
`define SLS_LMFC_ZERO           8'h00
`define SLS_LMFC_STEP           8'h01

`endif

// ===== rtl/sls_pkg.sv
/*
 * Types of the link layer setup block.
 * Assumes nothing of its surroundings.
 */
package sls_pkg;

    typedef enum logic [1:0] {
        SLS_LINK_IDLE,
        SLS_LINK_WAIT,
        SLS_LINK_LOCKED
    } sls_link_state_t;

endpackage : sls_pkg

// ===== rtl/sls_top.sv
/*
 * Receive data link layer setup: register bank, lane crossbar, lane
 * polarity, link enables, status select and SERDES PLL lock readback.
 * Assumes all inputs synchronous to mclk and a transmitter that sends
 * SYSREF edges after arming and keeps both links' parameters identical.
 */
// Behaviour
// - enabled, armed one-shot sync locks on a SYSREF edge; lock shows in sync status bit 3.
// - logical lanes with polarity mask bit set are inverted, others pass.
// - two-bit link enable field enables link 0 and link 1 independently.
// - status link select picks which link the status readback reports.
// - four crossbar registers map physical lanes onto logical lanes.
// - SERDES PLL status bit 0 reads 1 once enabled PLL is locked.
// - two links run independently; disabling one leaves the other untouched.
`timescale 1ns/1ps
`include "sls_params.svh"

module sls_top (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        sysref,
    input  wire logic        serdes_pll_locked,
    input  wire logic [63:0] phys_lane_data,
    output logic      [63:0] lane_data,
    output logic      [7:0]  lane_valid,
    output logic      [1:0]  sync_locked,
    output logic      [1:0]  lmfc_pulse,
    output logic             serdes_pll_enable
);

    typedef struct packed {
        logic [7:0]      sync_ctrl;
        logic [7:0]      link_ctrl;
        logic [7:0]      subclass;
        logic [7:0]      dly_a;
        logic [7:0]      dly_b;
        logic [7:0]      win_a;
        logic [7:0]      win_b;
        logic [3:0][7:0] xbar;
        logic [7:0]      pol;
        logic            pll_en;
        logic            pll_lock;
        logic            sysref_prev;
        logic [7:0]      rdata;
        logic            rvalid;
        logic [63:0]     lanes;
        logic [7:0]      valid;
    } sls_top_state_t;

    sls_top_state_t q;
    sls_top_state_t d;
    logic           sysref_edge;
    logic [1:0]     locked;
    logic [2:0]     sel0;

    assign sysref_edge = sysref && !q.sysref_prev;
    assign sel0        = q.xbar[0][2:0];

    // ------------------------------------------------------------------
    // per-link sync machines
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_link
            sls_link u_link (
                .mclk        (mclk),
                .reset       (reset),
                .link_enable (q.link_ctrl[g]),
                .sync_enable (q.sync_ctrl[`SLS_SYNC_EN_BIT]),
                .sync_arm    (q.sync_ctrl[`SLS_SYNC_ARM_BIT]),
                .sync_mode   (q.sync_ctrl[`SLS_SYNC_MODE_LSB +: 2]),
                .sysref_edge (sysref_edge),
                .locked      (locked[g]),
                .lmfc_pulse  (lmfc_pulse[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // register bank and lane path
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [2:0] sel;
        logic       lnk;
        sel = '0;
        lnk = '0;
        d = q;
        d.sysref_prev = sysref;
        d.pll_lock    = serdes_pll_locked;
        if (reg_wr)
        begin
            case (reg_addr)
                `SLS_ADDR_SYNC_CONTROL: d.sync_ctrl = reg_wdata;
                `SLS_ADDR_PLL_CONTROL:  d.pll_en    = reg_wdata[`SLS_PLL_BIT];
                `SLS_ADDR_LINK_CONTROL: d.link_ctrl = reg_wdata;
                `SLS_ADDR_SUBCLASS:     d.subclass  = reg_wdata;
                `SLS_ADDR_MF_DELAY_A:   d.dly_a     = reg_wdata;
                `SLS_ADDR_MF_DELAY_B:   d.dly_b     = reg_wdata;
                `SLS_ADDR_MF_WINDOW_A:  d.win_a     = reg_wdata;
                `SLS_ADDR_MF_WINDOW_B:  d.win_b     = reg_wdata;
                `SLS_ADDR_XBAR_0:       d.xbar[0]   = reg_wdata;
                `SLS_ADDR_XBAR_1:       d.xbar[1]   = reg_wdata;
                `SLS_ADDR_XBAR_2:       d.xbar[2]   = reg_wdata;
                `SLS_ADDR_XBAR_3:       d.xbar[3]   = reg_wdata;
                `SLS_ADDR_POLARITY:     d.pol       = reg_wdata;
                default:                d.pol       = q.pol;
            endcase
        end
        d.rvalid = reg_rd;
        d.rdata  = `SLS_RST_BYTE;
        if (reg_rd)
        begin
            case (reg_addr)
                `SLS_ADDR_SYNC_CONTROL: d.rdata = q.sync_ctrl;
                `SLS_ADDR_SYNC_STATUS:
                    d.rdata[`SLS_SYNC_LOCK_BIT] = locked[q.link_ctrl[`SLS_STATUS_SEL_BIT]];
                `SLS_ADDR_PLL_CONTROL:  d.rdata[`SLS_PLL_BIT] = q.pll_en;
                `SLS_ADDR_PLL_STATUS:   d.rdata[`SLS_PLL_BIT] = q.pll_en && q.pll_lock;
                `SLS_ADDR_LINK_CONTROL: d.rdata = q.link_ctrl;
                `SLS_ADDR_SUBCLASS:     d.rdata = q.subclass;
                `SLS_ADDR_MF_DELAY_A:   d.rdata = q.dly_a;
                `SLS_ADDR_MF_DELAY_B:   d.rdata = q.dly_b;
                `SLS_ADDR_MF_WINDOW_A:  d.rdata = q.win_a;
                `SLS_ADDR_MF_WINDOW_B:  d.rdata = q.win_b;
                `SLS_ADDR_XBAR_0:       d.rdata = q.xbar[0];
                `SLS_ADDR_XBAR_1:       d.rdata = q.xbar[1];
                `SLS_ADDR_XBAR_2:       d.rdata = q.xbar[2];
                `SLS_ADDR_XBAR_3:       d.rdata = q.xbar[3];
                `SLS_ADDR_POLARITY:     d.rdata = q.pol;
                default:                d.rdata = `SLS_RST_BYTE;
            endcase
        end
        for (int i = 0; i < 8; i++)
        begin
            sel = q.xbar[i / 2][(i % 2) * 3 +: 3];
            lnk = q.link_ctrl[`SLS_TWO_LINK_BIT] ? (i >= 4) : 1'b0;
            d.valid[i] = q.link_ctrl[lnk];
            d.lanes[i * 8 +: 8] = d.valid[i]
                ? (phys_lane_data[sel * 8 +: 8] ^ {8{q.pol[i]}})
                : `SLS_RST_BYTE;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            q           <= '0;
            q.xbar[0]   <= `SLS_RST_XBAR_0;
            q.xbar[1]   <= `SLS_RST_XBAR_1;
            q.xbar[2]   <= `SLS_RST_XBAR_2;
            q.xbar[3]   <= `SLS_RST_XBAR_3;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata         = q.rdata;
    assign reg_rvalid        = q.rvalid;
    assign lane_data         = q.lanes;
    assign lane_valid        = q.valid;
    assign sync_locked       = locked;
    assign serdes_pll_enable = q.pll_en;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_lock_on_sysref;
        @(posedge mclk) disable iff (reset)
        (q.sync_ctrl[`SLS_SYNC_EN_BIT] && q.sync_ctrl[`SLS_SYNC_ARM_BIT] && q.link_ctrl[0]
         && $past(q.sync_ctrl[`SLS_SYNC_EN_BIT]) && $past(q.link_ctrl[0])
         && q.sync_ctrl[`SLS_SYNC_MODE_LSB +: 2] == `SLS_SYNC_MODE_ONESHOT
         && sysref_edge && !locked[0]
         && $past(q.sync_ctrl[`SLS_SYNC_MODE_LSB +: 2]) == `SLS_SYNC_MODE_ONESHOT)
        ##1 (q.sync_ctrl[`SLS_SYNC_EN_BIT] && q.link_ctrl[0]) |-> locked[0];
    endproperty
    a_lock_on_sysref: assert property (p_lock_on_sysref)
        else $error("sync lock not set after sysref edge");

    property p_polarity;
        @(posedge mclk) disable iff (reset)
        q.link_ctrl[0] |=> lane_data[7:0] ==
            ($past(phys_lane_data[sel0 * 8 +: 8]) ^ {8{$past(q.pol[0])}});
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("logical lane 0 data or polarity wrong");

    property p_links_off;
        @(posedge mclk) disable iff (reset)
        (q.link_ctrl[1:0] == 2'h0) |=> (lane_valid == 8'h00 && lane_data == 64'h0);
    endproperty
    a_links_off: assert property (p_links_off)
        else $error("lane data passed with no link enabled");

    property p_status_select;
        @(posedge mclk) disable iff (reset)
        (reg_rd && reg_addr == `SLS_ADDR_SYNC_STATUS)
        |=> reg_rvalid && reg_rdata[`SLS_SYNC_LOCK_BIT] ==
            $past(locked[q.link_ctrl[`SLS_STATUS_SEL_BIT]]);
    endproperty
    a_status_select: assert property (p_status_select)
        else $error("sync status reports wrong link");

    property p_xbar_readback;
        @(posedge mclk) disable iff (reset)
        (reg_wr && reg_addr == `SLS_ADDR_XBAR_3)
        ##1 (reg_rd && !reg_wr && reg_addr == `SLS_ADDR_XBAR_3)
        |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_xbar_readback: assert property (p_xbar_readback)
        else $error("crossbar register lost its value");

    property p_pll_status;
        @(posedge mclk) disable iff (reset)
        (reg_rd && reg_addr == `SLS_ADDR_PLL_STATUS)
        |=> reg_rdata == {7'h00, $past(serdes_pll_enable && q.pll_lock)};
    endproperty
    a_pll_status: assert property (p_pll_status)
        else $error("pll status readback wrong");

    property p_link_ctrl_fields;
        @(posedge mclk) disable iff (reset)
        (reg_wr && reg_addr == `SLS_ADDR_LINK_CONTROL) |=>
            q.link_ctrl[`SLS_CHECKSUM_BIT] == $past(reg_wdata[`SLS_CHECKSUM_BIT])
            && q.link_ctrl[`SLS_TWO_LINK_BIT] == $past(reg_wdata[`SLS_TWO_LINK_BIT])
            && q.link_ctrl[`SLS_STATUS_SEL_BIT] == $past(reg_wdata[`SLS_STATUS_SEL_BIT]);
    endproperty
    a_link_ctrl_fields: assert property (p_link_ctrl_fields)
        else $error("link control fields not stored");

    property p_link_independent;
        @(posedge mclk) disable iff (reset)
        ($fell(q.link_ctrl[0]) && q.link_ctrl[1] && locked[1]
         && q.sync_ctrl[`SLS_SYNC_EN_BIT]) |=> locked[1];
    endproperty
    a_link_independent: assert property (p_link_independent)
        else $error("disabling link 0 disturbed link 1");

    property p_disable_clears;
        @(posedge mclk) disable iff (reset)
        $fell(q.link_ctrl[1]) |=> !locked[1] && !lane_valid[7];
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disabled link kept sync state or data");

endmodule : sls_top

// ===== test/sls_tx_model.sv
/*
 * Transmitter model: drives SYSREF and the eight physical lanes.
 * Assumes the bench asks for each SYSREF edge with a one-cycle fire pulse.
 */
`timescale 1ns/1ps

module sls_tx_model (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        fire,
    input  wire logic [63:0] pattern,
    output logic             sysref,
    output logic      [63:0] phys_lane_data
);
    logic [2:0] hold_q;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            hold_q         <= 3'h0;
            sysref         <= 1'b0;
            phys_lane_data <= 64'h0;
        end
        else
        begin
            if (fire)
                hold_q <= 3'h4;
            else if (hold_q != 3'h0)
                hold_q <= hold_q - 3'h1;
            sysref         <= (hold_q != 3'h0); // edge sent after arming
            phys_lane_data <= pattern; // one framing for both links
        end
    end
endmodule : sls_tx_model

// ===== test/tb_top.sv
/*
 * Self-checking bench of the link layer setup block.
 * Assumes the transmitter model beside it and a 250 MHz mclk.
 */
`timescale 1ns/1ps

module tb_top;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        serdes_pll_locked = 1'b0;
    logic        fire = 1'b0;
    logic [63:0] pattern = 64'h0;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        sysref;
    logic [63:0] phys_lane_data;
    logic [63:0] lane_data;
    logic [7:0]  lane_valid;
    logic [1:0]  sync_locked;
    logic [1:0]  lmfc_pulse;
    logic        serdes_pll_enable;
    int          n_errors = 0;
    int          num_checks = 0;

    always #2 mclk = ~mclk;

    sls_tx_model tx_u (.mclk(mclk), .reset(reset), .fire(fire), .pattern(pattern),
        .sysref(sysref), .phys_lane_data(phys_lane_data));

    sls_top dut_u (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sysref(sysref), .serdes_pll_locked(serdes_pll_locked),
        .phys_lane_data(phys_lane_data), .lane_data(lane_data), .lane_valid(lane_valid),
        .sync_locked(sync_locked), .lmfc_pulse(lmfc_pulse),
        .serdes_pll_enable(serdes_pll_enable));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(64'(reg_rvalid), 64'h1, "read answer");
        chk(64'(reg_rdata), 64'(e), "read data");
    endtask : rd

    task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(64'(reg_rvalid), 64'h1, "read answer");
        chk(64'(reg_rdata), 64'(d), "read after write");
    endtask : wr_rd

    task automatic send_sysref();
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        tick(2);
    endtask : send_sysref

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        chk(64'({sync_locked, lmfc_pulse, lane_valid, serdes_pll_enable}), 64'h0, "rst out");
        rd(12'h308, 8'h08);
        rd(12'h309, 8'h1a);
        rd(12'h30a, 8'h2c);
        rd(12'h30b, 8'h3e);
        rd(12'h334, 8'h00);
        rd(12'h03a, 8'h00);
        rd(12'h281, 8'h00);
        rd(12'h100, 8'h00);
        wr(12'h03b, 8'hff);
        rd(12'h03b, 8'h00);
        wr(12'h300, 8'h4f);
        rd(12'h300, 8'h4f);
        wr(12'h300, 8'h00);
    endtask : t_regs

    task automatic t_sync();
        int n;
        wr(12'h300, 8'h0b);
        wr(12'h03a, 8'h01);
        wr(12'h03a, 8'h81);
        wr(12'h03a, 8'hc1);
        tick(2);
        chk(64'(sync_locked), 64'h0, "lock before edge");
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        n = 0;
        while (sync_locked !== 2'b11 && n < 20)
        begin
            tick(1);
            n++;
        end
        chk(64'(sync_locked), 64'h3, "both links lock");
        rd(12'h03b, 8'h08);
        n = 0;
        while (lmfc_pulse[0] !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (lmfc_pulse[0] !== 1'b1 && n < 40);
        chk(64'(n), 64'd32, "multiframe period");
        wr(12'h300, 8'h0e);
        tick(2);
        chk(64'(sync_locked), 64'h2, "link 0 off");
        chk(64'(lane_valid), 64'hf0, "link 0 lanes");
        rd(12'h03b, 8'h08);
        wr(12'h300, 8'h0b);
        send_sysref();
        chk(64'(sync_locked), 64'h3, "link 0 relock");
        wr(12'h300, 8'h0d);
        tick(2);
        chk(64'(sync_locked), 64'h1, "link 1 off");
        chk(64'(lane_valid), 64'h0f, "link 1 lanes");
        rd(12'h03b, 8'h00);
        wr(12'h300, 8'h09);
        rd(12'h03b, 8'h08);
        wr(12'h03a, 8'hc2);
        send_sysref();
        chk(64'(lmfc_pulse[0]), 64'h1, "continuous realign");
        tick(1);
        chk(64'(lmfc_pulse[0]), 64'h0, "pulse one cycle");
    endtask : t_sync

    task automatic t_lanes();
        logic [63:0] p;
        logic [63:0] e;
        logic [7:0]  v;
        wr(12'h300, 8'h0b);
        for (int j = 0; j < 4; j++)
            wr(12'h308 + 12'(j), {2'b00, 3'(6 - 2 * j), 3'(7 - 2 * j)});
        wr_rd(12'h30b, 8'h01);
        wr(12'h334, 8'ha5);
        for (int i = 0; i < 8; i++)
        begin
            p[8*i+:8] = 8'(8'h11 * i);
            v = 8'(8'h11 * (7 - i));
            e[8*i+:8] = (8'ha5 >> i) & 8'h01 ? ~v : v;
        end
        @(posedge mclk);
        pattern <= p;
        tick(3);
        chk(lane_data, e, "mapped lanes");
        chk(64'(lane_valid), 64'hff, "lanes valid");
        wr(12'h300, 8'h00);
        tick(2);
        chk(lane_data, 64'h0, "lanes off");
        chk(64'(lane_valid), 64'h0, "valid off");
    endtask : t_lanes

    task automatic t_pll();
        @(posedge mclk);
        serdes_pll_locked <= 1'b1;
        rd(12'h281, 8'h00);
        wr(12'h280, 8'h01);
        tick(2);
        chk(64'(serdes_pll_enable), 64'h1, "pll enable");
        rd(12'h281, 8'h01);
        @(posedge mclk);
        serdes_pll_locked <= 1'b0;
        tick(2);
        rd(12'h281, 8'h00);
    endtask : t_pll

    initial
    begin
        #40000;
        n_errors++;
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        tick(1);
        t_regs();
        t_sync();
        t_lanes();
        t_pll();
        complete_run();
    end
endmodule : tb_top
